//--- hw/tsx_defines.vh
// Purpose: constants for the auxiliary transmit slot block
// Assumes: 8-bit registers at byte offsets on the control port
// Notes:   definitions only
`ifndef TSX_DEFINES_VH
`define TSX_DEFINES_VH
// ==========================================================
// register offsets and reset values
`define TSX_OFS_MON      8'h10
`define TSX_OFS_STAT     8'h13
`define TSX_OFS_OCPIN    8'h15
`define TSX_RST_MON      8'h04
`define TSX_RST_STAT     8'h08
`define TSX_RST_OCPIN    8'h00
// ==========================================================
// field positions
`define TSX_LEN_BIT      7
`define TSX_EN_BIT       6
`define TSX_REMAP_BIT    7
`define TSX_TRIM_HI      7
`define TSX_TRIM_LO      5
`define TSX_PINF_HI      4
`define TSX_PINF_LO      2
// ==========================================================
// pin function codes
`define TSX_PIN_GAIN     3'h0
`define TSX_PIN_OFF      3'h2
`define TSX_PIN_GPI      3'h3
`define TSX_PIN_GPO      3'h4
// ==========================================================
// frame timing: slot is 32 bit clocks, offset from frame start
`define TSX_SLOT_BITS    6'h20
`define TSX_TX_OFFSET    6'h01
`endif

//--- hw/tsx_skid.v
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: same clock on both sides
// Notes:   ready depends only on occupancy, so no comb path
`timescale 1ns/1ps
module tsx_skid (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire [15:0] in_data,
  input  wire        in_valid,
  output wire        in_ready,
  output wire [15:0] out_data,
  output wire        out_valid,
  input  wire        out_ready
);
  reg [15:0] mem_r [0:1];
  reg        wp_r;
  reg        rp_r;
  reg [1:0]  cnt_r;
  wire       push;
  wire       pop;
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // ==========================================================
  // pointer and count update
  always @(posedge sys_clk) begin
    if (reset) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // tsx_skid

//--- hw/tsx_aux_slots.v
// Purpose: auxiliary monitor and status slots on the serial output
// Assumes: bit clock and frame sync arrive asynchronously; control port is a
//          simple synchronous write/read strobe pair
// Notes:   serial output launches after the falling bit clock, one slot is 32 bits
`timescale 1ns/1ps
`include "tsx_defines.vh"
module tsx_aux_slots (
  input  wire        sys_clk,
  input  wire        reset,
  // control port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // serial link pins
  input  wire        bit_clk,
  input  wire        frame_sync,
  output reg         serial_data_output,
  output reg         serial_data_output_oe,
  // configuration of the serial link
  input  wire        unused_fill_hiz,
  input  wire        rate_192k,
  // monitor samples from the converter
  input  wire [15:0] mon_low_rail,
  input  wire [15:0] mon_high_rail,
  input  wire [15:0] mon_temp,
  input  wire [15:0] mon_marker,
  // raw status flags
  input  wire        undervoltage_lockout,
  input  wire        overcurrent_flag,
  input  wire        overtemp_flag,
  input  wire        overtemp_shutdown_flag,
  input  wire        overpower_threshold_one,
  input  wire        overpower_threshold_two,
  input  wire        brownout_protection,
  input  wire        limiter_active,
  input  wire        noise_gate,
  input  wire        stage_on_high_rail,
  input  wire        device_active,
  // inter-chip pin and trim
  input  wire        interchip_link_pin_in,
  output reg         interchip_link_pin_out,
  output reg         interchip_link_pin_oe,
  output reg         gain_slot_mode,
  input  wire        gain_slot_bit,
  output reg         gpi_level,
  input  wire        gpo_level,
  output reg  [2:0]  lowside_overcurrent_trim,
  output reg  [3:0]  oc_trim_step,
  output reg         oc_trim_raise
);
  // ==========================================================
  // registers
  reg  [7:0] mon_cfg_r;
  reg  [7:0] stat_cfg_r;
  reg  [7:0] ocpin_cfg_r;
  wire       monitor_sample_slot_len = mon_cfg_r[`TSX_LEN_BIT];
  wire       monitor_sample_tx_en    = mon_cfg_r[`TSX_EN_BIT];
  wire [5:0] monitor_sample_slot_sel = mon_cfg_r[5:0];
  wire       overpower_flag_remap    = stat_cfg_r[`TSX_REMAP_BIT];
  wire       status_tx_en            = stat_cfg_r[`TSX_EN_BIT];
  wire [5:0] status_slot_sel         = stat_cfg_r[5:0];
  wire [2:0] interchip_pin_function  = ocpin_cfg_r[`TSX_PINF_HI:`TSX_PINF_LO];
  wire [2:0] trim_code               = ocpin_cfg_r[`TSX_TRIM_HI:`TSX_TRIM_LO];

  // register writes; reserved bits 1:0 of the trim register stay zero
  // unmapped offsets fall to the default branch and are dropped
  always @(posedge sys_clk) begin
    if (reset) begin
      mon_cfg_r   <= `TSX_RST_MON;
      stat_cfg_r  <= `TSX_RST_STAT;
      ocpin_cfg_r <= `TSX_RST_OCPIN;
    end else if (reg_wr) begin
      case (reg_addr)
        `TSX_OFS_MON:   mon_cfg_r   <= reg_wdata;
        `TSX_OFS_STAT:  stat_cfg_r  <= reg_wdata;
        `TSX_OFS_OCPIN: ocpin_cfg_r <= {reg_wdata[7:2], 2'h0};
        default: ;
      endcase
    end
  end

  // read port; unmapped addresses read zero
  always @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `TSX_OFS_MON:   reg_rdata <= mon_cfg_r;
        `TSX_OFS_STAT:  reg_rdata <= stat_cfg_r;
        `TSX_OFS_OCPIN: reg_rdata <= ocpin_cfg_r;
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // over-current trim decode: step in tens of percent
  // lowering codes 4 to 7 give 40 down to 10, four minus the low bits
  always @(posedge sys_clk) begin
    if (reset) begin
      lowside_overcurrent_trim <= 3'h0;
      oc_trim_step             <= 4'h0;
      oc_trim_raise            <= 1'b0;
    end else begin
      lowside_overcurrent_trim <= trim_code;
      oc_trim_raise            <= (trim_code != 3'h0) & ~trim_code[2];
      if (trim_code[2])
        oc_trim_step <= {1'b0, 3'h4 - {1'b0, trim_code[1:0]}};
      else
        oc_trim_step <= {2'h0, trim_code[1:0]};
    end
  end

  // ==========================================================
  // inter-chip pin: reserved codes behave like disabled buffers
  // gpi level holds its last value while another function is selected
  reg ic_s1_r;
  reg ic_s2_r;
  always @(posedge sys_clk) begin
    if (reset) begin
      ic_s1_r                <= 1'b0;
      ic_s2_r                <= 1'b0;
      interchip_link_pin_out <= 1'b0;
      interchip_link_pin_oe  <= 1'b0;
      gain_slot_mode         <= 1'b0;
      gpi_level              <= 1'b0;
    end else begin
      ic_s1_r <= interchip_link_pin_in;
      ic_s2_r <= ic_s1_r;
      gain_slot_mode <= (interchip_pin_function == `TSX_PIN_GAIN);
      case (interchip_pin_function)
        `TSX_PIN_GAIN: begin
          interchip_link_pin_out <= gain_slot_bit;
          interchip_link_pin_oe  <= 1'b1;
        end
        `TSX_PIN_GPI: begin
          interchip_link_pin_out <= 1'b0;
          interchip_link_pin_oe  <= 1'b0;
          gpi_level              <= ic_s2_r;
        end
        `TSX_PIN_GPO: begin
          interchip_link_pin_out <= gpo_level;
          interchip_link_pin_oe  <= 1'b1;
        end
        default: begin
          interchip_link_pin_out <= 1'b0;
          interchip_link_pin_oe  <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // link pin synchronisers and edge detect
  reg bclk_s1_r;
  reg bclk_s2_r;
  reg bclk_s3_r;
  reg fs_s1_r;
  reg fs_s2_r;
  always @(posedge sys_clk) begin
    if (reset) begin
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      bclk_s3_r <= 1'b0;
      fs_s1_r   <= 1'b0;
      fs_s2_r   <= 1'b0;
    end else begin
      bclk_s1_r <= bit_clk;
      bclk_s2_r <= bclk_s1_r;
      bclk_s3_r <= bclk_s2_r;
      fs_s1_r   <= frame_sync;
      fs_s2_r   <= fs_s1_r;
    end
  end
  // edges use stages two and three; stage one feeds nothing else
  wire bclk_rise = bclk_s2_r & ~bclk_s3_r;
  wire bclk_fall = ~bclk_s2_r & bclk_s3_r;

  // ==========================================================
  // frame position: frame start is sync seen high on a rising bit clock
  reg        fs_prev_r;
  reg        in_frame_r;
  reg [5:0]  bit_cnt_r;
  reg [5:0]  slot_r;
  reg [4:0]  bit_idx_r;
  // fs_prev moves only on bit clock rises, so a long sync counts once
  wire       frame_start = bclk_rise & fs_s2_r & ~fs_prev_r;
  always @(posedge sys_clk) begin
    if (reset) begin
      fs_prev_r  <= 1'b0;
      in_frame_r <= 1'b0;
      bit_cnt_r  <= 6'h00;
      slot_r     <= 6'h00;
      bit_idx_r  <= 5'h00;
    end else if (bclk_rise) begin
      fs_prev_r <= fs_s2_r;
      if (frame_start) begin
        in_frame_r <= 1'b1;
        bit_cnt_r  <= 6'h00;
        slot_r     <= 6'h00;
        bit_idx_r  <= 5'h00;
      end else if (in_frame_r) begin
        if (bit_cnt_r != `TSX_TX_OFFSET)
          bit_cnt_r <= bit_cnt_r + 6'h01;
        else if (bit_idx_r == 5'h1f) begin
          bit_idx_r <= 5'h00;
          slot_r    <= slot_r + 6'h01;
        end else
          bit_idx_r <= bit_idx_r + 5'h01;
      end
    end
  end
  wire data_phase = in_frame_r & (bit_cnt_r == `TSX_TX_OFFSET);

  // ==========================================================
  // status word capture at frame start keeps all bits coherent
  // remap only steers bits 6 and 5; the raw flags are left alone
  reg  [7:0] status_word_r;
  wire       st_b6 = overpower_flag_remap ? overpower_threshold_one
                                          : overcurrent_flag;
  wire       st_b5 = overpower_flag_remap ? (overpower_threshold_two |
                                             overtemp_shutdown_flag)
                                          : overtemp_flag;
  always @(posedge sys_clk) begin
    if (reset)
      status_word_r <= 8'h00;
    else if (frame_start)
      status_word_r <= {undervoltage_lockout,
                        st_b6, st_b5,
                        brownout_protection,
                        limiter_active,
                        noise_gate,
                        stage_on_high_rail,
                        device_active};
  end

  // ==========================================================
  // monitor sequence: one item per frame, doubled at the higher rate
  reg  [2:0]  seq_r;
  wire [1:0]  item = rate_192k ? seq_r[2:1] : seq_r[1:0];
  reg  [15:0] mon_pick;
  always @* begin
    case (item)
      2'h0:    mon_pick = mon_low_rail;
      2'h1:    mon_pick = mon_high_rail;
      2'h2:    mon_pick = mon_temp;
      default: mon_pick = mon_marker;
    endcase
  end

  // samples pass a small buffer so a busy serializer loses none
  wire [15:0] buf_data;
  wire        buf_valid;
  wire        buf_in_ready;
  wire        mon_load = frame_start & monitor_sample_tx_en;
  wire        buf_pop  = frame_start & buf_valid;
  tsx_skid u_buf (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_data   (mon_pick),
    .in_valid  (mon_load),
    .in_ready  (buf_in_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (frame_start)
  );

  // sequence advances only when a sample is really accepted
  // clearing the enable restarts the order at the low rail
  reg [15:0] mon_word_r;
  reg        mon_have_r;
  always @(posedge sys_clk) begin
    if (reset) begin
      seq_r      <= 3'h0;
      mon_word_r <= 16'h0000;
      mon_have_r <= 1'b0;
    end else begin
      if (mon_load & buf_in_ready)
        seq_r <= rate_192k ? seq_r + 3'h1 : {1'b0, seq_r[1:0] + 2'h1};
      if (~monitor_sample_tx_en)
        seq_r <= 3'h0;
      if (frame_start) begin
        mon_have_r <= buf_pop & monitor_sample_tx_en;
        mon_word_r <= buf_data;
      end
    end
  end

  // ==========================================================
  // bit selection for the current slot position
  wire in_mon  = monitor_sample_tx_en & mon_have_r &
                 (slot_r == monitor_sample_slot_sel) &
                 (monitor_sample_slot_len ? ~bit_idx_r[4]
                                          : (bit_idx_r[4:3] == 2'h0));
  // status wins when both selects name the same slot
  wire in_stat = status_tx_en & (slot_r == status_slot_sel) &
                 (bit_idx_r[4:3] == 2'h0);
  wire mon_bit  = mon_word_r[4'hf - bit_idx_r[3:0]];
  wire stat_bit = status_word_r[3'h7 - bit_idx_r[2:0]];

  // launch on falling bit clock so the host samples on the rising one
  // a released pin parks its data at zero so nothing inside floats
  always @(posedge sys_clk) begin
    if (reset) begin
      serial_data_output    <= 1'b0;
      serial_data_output_oe <= 1'b0;
    end else if (bclk_fall) begin
      if (data_phase & in_stat) begin
        serial_data_output    <= stat_bit;
        serial_data_output_oe <= 1'b1;
      end else if (data_phase & in_mon) begin
        serial_data_output    <= mon_bit;
        serial_data_output_oe <= 1'b1;
      end else begin
        serial_data_output    <= 1'b0;
        serial_data_output_oe <= ~unused_fill_hiz;
      end
    end
  end
endmodule // tsx_aux_slots

//--- sim/tsx_aux_checker.sv
// Purpose: port assertions for the aux slot block
// Assumes: one clock domain, sync active-high reset
// Notes:   bound to the block from the testbench top
`timescale 1ns/1ps
module tsx_aux_checker (
  input wire       sys_clk,
  input wire       reset,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       bit_clk,
  input wire       serial_data_output,
  input wire       serial_data_output_oe,
  input wire [2:0] lowside_overcurrent_trim,
  input wire [3:0] oc_trim_step,
  input wire       oc_trim_raise
);
  // ==========================================================
  // helpers: lowering codes run 40 down to 10 percent
  function automatic [3:0] step_of(input [2:0] c);
    step_of = c[2] ? 4'h8 - {1'b0, c} : {1'b0, c};
  endfunction
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence trim_settled; $stable(lowside_overcurrent_trim) [*3]; endsequence
  sequence mon_wr; reg_wr && reg_addr == 8'h10; endsequence
  sequence mon_rd; reg_rd && !reg_wr && reg_addr == 8'h10; endsequence
  // ==========================================================
  // properties
  quiet_reset_a: assert property (disable iff (1'b0)
    reset |=> !serial_data_output_oe && reg_rdata == 8'h00) else $error("output busy in reset");
  unmapped_read_a: assert property (reg_rd && reg_addr != 8'h10 && reg_addr != 8'h13
    && reg_addr != 8'h15 |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  pin_reserved_a: assert property (reg_rd && reg_addr == 8'h15 |=> reg_rdata[1:0] == 2'h0)
    else $error("reserved bits read nonzero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  mon_readback_a: assert property (mon_wr ##1 !reg_wr ##1 mon_rd
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("monitor config readback wrong");
  trim_step_a: assert property (trim_settled |-> oc_trim_step == step_of(lowside_overcurrent_trim))
    else $error("trim step wrong");
  trim_dir_a: assert property (trim_settled ##0 (lowside_overcurrent_trim != 3'h0)
    |-> oc_trim_raise == !lowside_overcurrent_trim[2]) else $error("trim direction wrong");
  launch_fall_a: assert property ($changed(serial_data_output) |-> !$past(bit_clk))
    else $error("serial data moved in high half");
endmodule // tsx_aux_checker

//--- sim/tsx_tdm_host.sv
// Purpose: host end of the frame link, makes clock and sync, captures bits
// Assumes: 80 ns bit clock, 96 captured bits per frame
// Notes:   clock stands low between frames; phase drifts each frame
`timescale 1ns/1ps
module tsx_tdm_host (
  output reg  bit_clk,
  output reg  frame_sync,
  input  wire serial_data_output,
  input  wire serial_data_output_oe
);
  reg [0:95] rx_data;
  reg [0:95] rx_oe;
  initial begin
    bit_clk = 1'b0;
    frame_sync = 1'b0;
  end
  // ==========================================================
  // sync over rise 0, one offset clock, then bits taken on each rise
  task run_frame;
    integer k;
    begin
      #1.3 frame_sync = 1'b1;
      for (k = 0; k < 98; k = k + 1) begin
        #40 bit_clk = 1'b1;
        // a released line shows the inverse of what was last parked on it
        if (k >= 2) rx_data[k-2] = serial_data_output_oe ? serial_data_output : ~serial_data_output;
        if (k >= 2) rx_oe[k-2] = serial_data_output_oe;
        #20 frame_sync = 1'b0;
        #20 bit_clk = 1'b0;
      end
    end
  endtask
endmodule // tsx_tdm_host

//--- sim/tdm_tx_aux_slot_config_test.sv
// Purpose: register and frame tests of the aux slot block
// Assumes: monitor in slot 1, status in slot 2 of a short frame
// Notes:   monitor order checked phase-free, buffer start is one frame late
`timescale 1ns/1ps
module tdm_tx_aux_slot_config_test;
  reg         sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rd_v;
  reg         unused_fill_hiz = 1'b0, rate_192k = 1'b0, gain_slot_bit = 1'b1;
  reg         interchip_link_pin_in = 1'b1, gpo_level = 1'b1;
  reg  [15:0] mon_low_rail = 16'ha1b2, mon_high_rail = 16'hc3d4;
  reg  [15:0] mon_temp = 16'he5f6, mon_marker = 16'h1789, expv;
  reg  [10:0] flg = 11'h000;
  reg  [15:0] w [0:7];
  integer     err_count = 0, n_compared = 0, i, j, f, hit, ok;
  wire [7:0]  reg_rdata;
  wire [2:0]  lowside_overcurrent_trim;
  wire [3:0]  oc_trim_step;
  wire        bit_clk, frame_sync, serial_data_output, serial_data_output_oe, oc_trim_raise;
  wire        interchip_link_pin_out, interchip_link_pin_oe, gain_slot_mode, gpi_level;
  // ==========================================================
  // clock, partner and design
  always #2.5 sys_clk = ~sys_clk;
  tsx_tdm_host u_host (.bit_clk, .frame_sync, .serial_data_output, .serial_data_output_oe);
  tsx_aux_slots DUT (.sys_clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .bit_clk, .frame_sync, .serial_data_output, .serial_data_output_oe, .unused_fill_hiz,
    .rate_192k, .mon_low_rail, .mon_high_rail, .mon_temp, .mon_marker,
    .undervoltage_lockout(flg[7]), .overcurrent_flag(flg[6]), .overtemp_flag(flg[5]),
    .overtemp_shutdown_flag(flg[8]), .overpower_threshold_one(flg[9]),
    .overpower_threshold_two(flg[10]), .brownout_protection(flg[4]), .limiter_active(flg[3]),
    .noise_gate(flg[2]), .stage_on_high_rail(flg[1]), .device_active(flg[0]),
    .interchip_link_pin_in, .interchip_link_pin_out, .interchip_link_pin_oe, .gain_slot_mode,
    .gain_slot_bit, .gpi_level, .gpo_level, .lowside_overcurrent_trim, .oc_trim_step,
    .oc_trim_raise);
  // ==========================================================
  // shared tasks
  task chk(input string what, input [15:0] exp, input [15:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task reg_write(input [7:0] a, input [7:0] d);
    begin
      @(negedge sys_clk);
      reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
    end
  endtask
  // read data lands one cycle after the strobe and then stands
  task reg_read(input [7:0] a);
    begin
      @(negedge sys_clk);
      reg_rd = 1'b1; reg_addr = a;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      @(negedge sys_clk);
      rd_v = reg_rdata;
    end
  endtask
  function [15:0] item(input integer n);
    item = n == 0 ? mon_low_rail : n == 1 ? mon_high_rail : n == 2 ? mon_temp : mon_marker;
  endfunction
  // two settling frames, then a full cycle of the order at any phase
  task mon_seq(input integer rep, input integer len16);
    begin
      repeat (2) u_host.run_frame;
      for (f = 0; f < 4 * rep; f = f + 1) begin
        u_host.run_frame;
        w[f] = u_host.rx_data[32:47];
        chk("monitor oe", 16'hffff, u_host.rx_oe[32:47]);
        chk("status off", 16'h0000, {8'h00, u_host.rx_data[64:71]});
      end
      ok = 0;
      for (j = 0; j < 4 * rep; j = j + 1) begin
        hit = 1;
        for (f = 0; f < 4 * rep; f = f + 1) begin
          expv = item(((j + f) % (4 * rep)) / rep);
          if (len16 == 0) expv = {expv[15:8], 8'h00};
          if (w[f] !== expv) hit = 0;
        end
        if (hit == 1) ok = 1;
      end
      chk("monitor order", 16'h0001, ok[15:0]);
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // ==========================================================
  // watchdog: the run needs about 0.3 ms
  initial begin
    #450000;
    err_count = err_count + 1;
    print_verdict;
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    reg_read(8'h10); chk("mon cfg", 16'h0004, rd_v);
    reg_read(8'h13); chk("stat cfg", 16'h0008, rd_v);
    reg_read(8'h15); chk("pin cfg", 16'h0000, rd_v);
    reg_read(8'h11); chk("unmapped", 16'h0000, rd_v);
    for (i = 0; i < 8; i = i + 1) begin
      reg_write(8'h15, {i[2:0], i[2:0], 2'b11});
      reg_read(8'h15); chk("pin cfg", {8'h00, i[2:0], i[2:0], 2'b00}, rd_v);
      repeat (4) @(negedge sys_clk);
      chk("trim", i[2:0], lowside_overcurrent_trim);
      chk("trim step", i < 4 ? i[3:0] : 4'h8 - i[3:0], oc_trim_step);
      if (i != 0) chk("trim raise", i < 4, oc_trim_raise);
      chk("gain mode", i == 0, gain_slot_mode);
      if (i != 0) chk("pin oe", i == 4, interchip_link_pin_oe);
      if (i == 0) chk("gain out", 16'h0001, interchip_link_pin_out);
      if (i == 4) chk("pin out", 16'h0001, interchip_link_pin_out);
      if (i == 3) chk("pin in", 16'h0001, gpi_level);
    end
    $display("test registers done");
    reg_write(8'h13, 8'h02);
    reg_write(8'h10, 8'hc1);
    reg_read(8'h10); chk("mon cfg", 16'h00c1, rd_v);
    mon_seq(1, 1);
    reg_write(8'h10, 8'h41);
    rate_192k = 1'b1;
    mon_seq(2, 0);
    $display("test monitor done");
    reg_write(8'h10, 8'h01);
    for (i = 0; i < 22; i = i + 1) begin
      reg_write(8'h13, {i >= 11, 1'b1, 6'h02});
      flg = 11'h001 << (i % 11);
      unused_fill_hiz = i[0];
      u_host.run_frame;
      expv = {8'h00, flg[7:0]};
      if (i >= 11) expv[6:5] = {flg[9], flg[10] | flg[8]};
      chk("status", expv, {8'h00, u_host.rx_data[64:71]});
      chk("fill oe", i[0] ? 16'h0000 : 16'hffff, u_host.rx_oe[32:47]);
      if (!i[0]) chk("mon off", 16'h0000, u_host.rx_data[32:47]);
    end
    $display("test status done");
    print_verdict;
  end
endmodule // tdm_tx_aux_slot_config_test

bind tsx_aux_slots tsx_aux_checker u_chk (.sys_clk, .reset, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .bit_clk, .serial_data_output, .serial_data_output_oe,
  .lowside_overcurrent_trim, .oc_trim_step, .oc_trim_raise);
